// ==== rtctcf_pkg.sv ====
// Shared constants and carrier types of the timekeeping and alarm flag core.
`default_nettype none
package rtctcf_pkg;
    // ************************************************************
    // Register addresses
    // ************************************************************
    localparam logic [3:0] ADDR_SECONDS   = 4'h0;
    localparam logic [3:0] ADDR_MINUTES   = 4'h1;
    localparam logic [3:0] ADDR_HOURS     = 4'h2;
    localparam logic [3:0] ADDR_WEEKDAY   = 4'h3;
    localparam logic [3:0] ADDR_MDAY      = 4'h4;
    localparam logic [3:0] ADDR_MONTH     = 4'h5;
    localparam logic [3:0] ADDR_YEAR      = 4'h6;
    localparam logic [3:0] ADDR_FLAGS     = 4'hF;

    // ************************************************************
    // Field layout
    // ************************************************************
    localparam int SEC_W       = 7;
    localparam int MIN_W       = 7;
    localparam int HOUR_W      = 6;
    localparam int WDAY_W      = 3;
    localparam int MDAY_W      = 6;
    localparam int MON_W       = 5;
    localparam int YEAR_W      = 8;
    localparam int HOUR_PM_BIT = 5;
    localparam int FLAG_DAILY  = 0;
    localparam int FLAG_WEEKLY = 1;
    localparam int NUM_ALARMS  = 2;

    // ************************************************************
    // Counter limits and reset values
    // ************************************************************
    localparam logic [7:0] BCD_59       = 8'h59;
    localparam logic [7:0] BCD_23       = 8'h23;
    localparam logic [7:0] BCD_12       = 8'h12;
    localparam logic [7:0] BCD_11       = 8'h11;
    localparam logic [7:0] BCD_99       = 8'h99;
    localparam logic [7:0] BCD_01       = 8'h01;
    localparam logic [7:0] BCD_00       = 8'h00;
    localparam logic [2:0] WDAY_LAST    = 3'h6;
    localparam logic [7:0] DAYS_31      = 8'h31;
    localparam logic [7:0] DAYS_30      = 8'h30;
    localparam logic [7:0] DAYS_29      = 8'h29;
    localparam logic [7:0] DAYS_28      = 8'h28;
    localparam logic [7:0] MON_FEB      = 8'h02;
    localparam logic [7:0] RST_TIME     = 8'h00;
    localparam logic [7:0] RST_DATE     = 8'h01;

    // ************************************************************
    // Timing
    // ************************************************************
    localparam int CLK_PERIOD_NS   = 10;
    localparam int SECOND_NS       = 1000000000;
    localparam int ALARM_DELAY_NS  = 15000;
    localparam int ALARM_DELAY_CYC = (ALARM_DELAY_NS / CLK_PERIOD_NS < 1) ? 1 :
                                     ALARM_DELAY_NS / CLK_PERIOD_NS;
    localparam int SEC_DIV_CYC     = SECOND_NS / CLK_PERIOD_NS;
    localparam int DLY_W           = 11;
    localparam int DIV_W           = 27;

    // ************************************************************
    // Carrier types
    // ************************************************************
    typedef struct packed {
        logic       we;
        logic [3:0] addr;
        logic [7:0] wdata;
    } rtctcf_req_t;
endpackage
`default_nettype wire

// ==== rtctcf_core.sv ====
// Time and calendar counters with alarm match flags and a link-clocked register port.
//
// Operation
// - Alarm flag sets about 15 us after time matches alarm, when enabled.
// - Flag cleared by writing zero or by dropping its enable; clearing releases interrupt output high.
// - After clearing, next alarm match drives output low and sets flag again.
// - Writing one to an alarm flag changes nothing.
// - Flag reads zero while its alarm enable is zero.
// - Flag equals one exactly while its interrupt output is low.
// - Seconds count BCD 00..59, carry into minutes on wrap.
// - Minutes count BCD 00..59, carry into hours on wrap.
// - Hours carry to day on PM11 to AM12, or 23 to 00.
// - Writing seconds clears the sub-second divider.
// - Weekday steps 0 to 6 then back to 0 on each day carry.
// - Weekday values carry no fixed day meaning.
// - Day runs to 31 or 30 depending on month.
// - February runs to 29 in leap years, else 28.
// - Day wrap from last day to 1 increments month.
// - Month BCD 1..12, wrap to 1 increments year.
// - Year BCD 00..99, every multiple of four is leap.
// - Counts reset to 00:00:00, weekday 0, day and month 01, year 00; unused upper bits read zero.
`timescale 1ns/1ps
`default_nettype none
module rtctcf_core #(
    parameter int SEC_DIV = rtctcf_pkg::SEC_DIV_CYC
) (
    input  wire logic                      clk,
    input  wire logic                      nrst,
    input  wire logic                      ce,
    input  wire logic                      hour_mode_24,
    input  wire logic                      weekly_alarm_enable,
    input  wire logic                      daily_alarm_enable,
    input  wire logic                      weekly_alarm_equal,
    input  wire logic                      daily_alarm_equal,
    output logic                           irq_out_a_n,
    output logic                           irq_out_b_n,
    input  wire logic                      link_clk,
    input  wire logic                      host_req,
    input  wire rtctcf_pkg::rtctcf_req_t   host_cmd,
    output logic                           host_ready,
    output logic                           host_done,
    output logic [7:0]                     host_rdata
);
    // ************************************************************
    // Helper functions
    // ************************************************************
    function automatic logic [7:0] bcd_inc(input logic [7:0] v);
        logic [7:0] r;
        r = (v[3:0] == 4'h9) ? {v[7:4] + 4'h1, 4'h0} : v + 8'h01;
        return r;
    endfunction

    function automatic logic is_leap(input logic [7:0] y);
        logic r;
        r = y[4] ? (y[3:0] == 4'h2 || y[3:0] == 4'h6)
                 : (y[3:0] == 4'h0 || y[3:0] == 4'h4 || y[3:0] == 4'h8);
        return r;
    endfunction

    function automatic logic [7:0] month_last(input logic [7:0] m, input logic [7:0] y);
        logic [7:0] r;
        case (m)
            8'h04, 8'h06, 8'h09, 8'h11: r = rtctcf_pkg::DAYS_30;
            rtctcf_pkg::MON_FEB: r = is_leap(y) ? rtctcf_pkg::DAYS_29 : rtctcf_pkg::DAYS_28;
            default: r = rtctcf_pkg::DAYS_31;
        endcase
        return r;
    endfunction

    // ************************************************************
    // Link-side request holding and handshake
    // ************************************************************
    typedef enum logic [1:0] {
        RTCTCF_IDLE = 2'b01,
        RTCTCF_BUSY = 2'b10
    } rtctcf_link_state_t;

    rtctcf_link_state_t      lstate_reg;
    rtctcf_link_state_t      lstate_next;
    rtctcf_pkg::rtctcf_req_t lcmd_reg;
    logic                    lreq_tgl_reg;
    logic                    lack_s1_reg;
    logic                    lack_s2_reg;
    logic                    ldone_reg;
    logic [7:0]              lrdata_reg;
    logic                    lack_seen;
    logic                    ltake;

    // Command fields stay frozen while busy, so the core may sample them freely.
    assign host_ready = (lstate_reg == RTCTCF_IDLE);
    assign ltake      = host_ready && host_req;
    assign lack_seen  = (lstate_reg == RTCTCF_BUSY) && (lack_s2_reg == lreq_tgl_reg);

    always_comb begin
        case (lstate_reg)
            RTCTCF_IDLE: lstate_next = ltake ? RTCTCF_BUSY : RTCTCF_IDLE;
            RTCTCF_BUSY: lstate_next = lack_seen ? RTCTCF_IDLE : RTCTCF_BUSY;
            default:     lstate_next = RTCTCF_IDLE;
        endcase
    end

    logic       cack_tgl_reg;
    logic [7:0] crdata_reg;

    always_ff @(posedge link_clk or negedge nrst) begin
        if (!nrst) begin
            lstate_reg   <= RTCTCF_IDLE;
            lcmd_reg     <= '0;
            lreq_tgl_reg <= 1'b0;
            lack_s1_reg  <= 1'b0;
            lack_s2_reg  <= 1'b0;
            ldone_reg    <= 1'b0;
            lrdata_reg   <= 8'h00;
        end else begin
            lstate_reg  <= lstate_next;
            lack_s1_reg <= cack_tgl_reg;
            lack_s2_reg <= lack_s1_reg;
            ldone_reg   <= lack_seen;
            if (ltake) begin
                lcmd_reg     <= host_cmd;
                lreq_tgl_reg <= ~lreq_tgl_reg;
            end
            if (lack_seen) begin
                lrdata_reg <= crdata_reg;
            end
        end
    end

    assign host_done  = ldone_reg;
    assign host_rdata = lrdata_reg;

    // ************************************************************
    // Core-side request detection
    // ************************************************************
    logic creq_s1_reg;
    logic creq_s2_reg;
    logic creq_s3_reg;
    logic cexec;
    logic cwr;

    assign cexec = ce && (creq_s2_reg != creq_s3_reg);
    assign cwr   = cexec && lcmd_reg.we;

    // ************************************************************
    // Sub-second divider
    // ************************************************************
    logic [rtctcf_pkg::DIV_W-1:0] div_reg;
    logic                         tick;
    logic                         sec_write;

    assign sec_write = cwr && (lcmd_reg.addr == rtctcf_pkg::ADDR_SECONDS);
    assign tick      = ce && !sec_write && (div_reg == rtctcf_pkg::DIV_W'(SEC_DIV - 1));

    // ************************************************************
    // Time and calendar counters
    // ************************************************************
    logic [7:0] sec_reg;
    logic [7:0] min_reg;
    logic [7:0] hour_reg;
    logic [7:0] wday_reg;
    logic [7:0] mday_reg;
    logic [7:0] mon_reg;
    logic [7:0] year_reg;
    logic [7:0] sec_next;
    logic [7:0] min_next;
    logic [7:0] hour_next;
    logic [7:0] wday_next;
    logic [7:0] mday_next;
    logic [7:0] mon_next;
    logic [7:0] year_next;

    logic       sec_wrap;
    logic       min_wrap;
    logic       day_carry;
    logic       mday_wrap;
    logic       mon_wrap;
    logic       pm;
    logic [7:0] hr12;
    logic [7:0] hour_inc;
    logic [7:0] wdat;
    logic [7:0] hr12_inc;

    assign sec_wrap  = tick && (sec_reg == rtctcf_pkg::BCD_59);
    assign min_wrap  = sec_wrap && (min_reg == rtctcf_pkg::BCD_59);
    assign pm        = hour_reg[rtctcf_pkg::HOUR_PM_BIT];
    assign hr12      = {3'h0, hour_reg[4:0]};
    assign hr12_inc  = bcd_inc(hr12);
    // Bit 5 is the PM flag in 12-hour mode and part of the tens digit in 24-hour mode.
    assign day_carry = min_wrap && (hour_mode_24 ? (hour_reg == rtctcf_pkg::BCD_23)
                                                 : (pm && hr12 == rtctcf_pkg::BCD_11));
    assign mday_wrap = day_carry && (mday_reg == month_last(mon_reg, year_reg));
    assign mon_wrap  = mday_wrap && (mon_reg == rtctcf_pkg::BCD_12);
    assign wdat      = lcmd_reg.wdata;

    always_comb begin
        if (hour_mode_24) begin
            hour_inc = (hour_reg == rtctcf_pkg::BCD_23) ? rtctcf_pkg::BCD_00 : bcd_inc(hour_reg);
        end else if (hr12 == rtctcf_pkg::BCD_12) begin
            hour_inc = {2'b00, pm, 5'h01};
        end else if (hr12 == rtctcf_pkg::BCD_11) begin
            hour_inc = {2'b00, ~pm, 5'h12};
        end else begin
            hour_inc = {2'b00, pm, hr12_inc[4:0]};
        end
    end

    always_comb begin
        sec_next  = tick ? (sec_wrap ? rtctcf_pkg::BCD_00 : bcd_inc(sec_reg)) : sec_reg;
        min_next  = sec_wrap ? (min_wrap ? rtctcf_pkg::BCD_00 : bcd_inc(min_reg)) : min_reg;
        hour_next = min_wrap ? hour_inc : hour_reg;
        wday_next = wday_reg;
        if (day_carry) begin
            // Weekday counts in septimal steps; its meaning is left to software.
            wday_next = (wday_reg[2:0] == rtctcf_pkg::WDAY_LAST) ? 8'h00 : wday_reg + 8'h01;
        end
        mday_next = day_carry ? (mday_wrap ? rtctcf_pkg::BCD_01 : bcd_inc(mday_reg)) : mday_reg;
        mon_next  = mday_wrap ? (mon_wrap ? rtctcf_pkg::BCD_01 : bcd_inc(mon_reg)) : mon_reg;
        year_next = year_reg;
        if (mon_wrap) begin
            year_next = (year_reg == rtctcf_pkg::BCD_99) ? rtctcf_pkg::BCD_00
                                                         : bcd_inc(year_reg);
        end
        // A host write beats a carry in the same cycle; unused upper bits are dropped.
        if (cwr) begin
            case (lcmd_reg.addr)
                rtctcf_pkg::ADDR_SECONDS: sec_next  = {1'b0, wdat[rtctcf_pkg::SEC_W-1:0]};
                rtctcf_pkg::ADDR_MINUTES: min_next  = {1'b0, wdat[rtctcf_pkg::MIN_W-1:0]};
                rtctcf_pkg::ADDR_HOURS:   hour_next = {2'b00, wdat[rtctcf_pkg::HOUR_W-1:0]};
                rtctcf_pkg::ADDR_WEEKDAY: wday_next = {5'h00, wdat[rtctcf_pkg::WDAY_W-1:0]};
                rtctcf_pkg::ADDR_MDAY:    mday_next = {2'b00, wdat[rtctcf_pkg::MDAY_W-1:0]};
                rtctcf_pkg::ADDR_MONTH:   mon_next  = {3'h0, wdat[rtctcf_pkg::MON_W-1:0]};
                rtctcf_pkg::ADDR_YEAR:    year_next = wdat;
                default: ;
            endcase
        end
    end

    // ************************************************************
    // Alarm match flags
    // ************************************************************
    logic [rtctcf_pkg::NUM_ALARMS-1:0] alm_en;
    logic [rtctcf_pkg::NUM_ALARMS-1:0] alm_eq;
    logic [rtctcf_pkg::NUM_ALARMS-1:0] alm_flag_reg;
    logic [rtctcf_pkg::NUM_ALARMS-1:0] alm_flag_vis;
    logic                              flag_write;

    assign alm_en[rtctcf_pkg::FLAG_DAILY]  = daily_alarm_enable;
    assign alm_en[rtctcf_pkg::FLAG_WEEKLY] = weekly_alarm_enable;
    assign alm_eq[rtctcf_pkg::FLAG_DAILY]  = daily_alarm_equal;
    assign alm_eq[rtctcf_pkg::FLAG_WEEKLY] = weekly_alarm_equal;
    assign flag_write = cwr && (lcmd_reg.addr == rtctcf_pkg::ADDR_FLAGS);
    assign alm_flag_vis = alm_flag_reg & alm_en;

    genvar gi;
    generate
        for (gi = 0; gi < rtctcf_pkg::NUM_ALARMS; gi++) begin : g_alarm
            logic [rtctcf_pkg::DLY_W-1:0] dly_reg;
            logic                         eq_prev_reg;
            logic                         hit;
            logic                         clr;
            logic                         set;

            assign hit = alm_en[gi] && alm_eq[gi] && !eq_prev_reg;
            assign set = alm_en[gi] && (dly_reg == rtctcf_pkg::DLY_W'(1));
            // Only a written zero clears; a written one is ignored.
            assign clr = flag_write && !wdat[gi];

            always_ff @(posedge clk or negedge nrst) begin
                if (!nrst) begin
                    dly_reg      <= '0;
                    eq_prev_reg  <= 1'b0;
                    alm_flag_reg[gi] <= 1'b0;
                end else if (ce) begin
                    eq_prev_reg <= alm_eq[gi];
                    if (!alm_en[gi]) begin
                        dly_reg <= '0;
                    end else if (hit) begin
                        dly_reg <= rtctcf_pkg::DLY_W'(rtctcf_pkg::ALARM_DELAY_CYC);
                    end else if (dly_reg != '0) begin
                        dly_reg <= dly_reg - rtctcf_pkg::DLY_W'(1);
                    end
                    // A delayed set that falls due in the clearing cycle still sets the flag.
                    if (!alm_en[gi]) begin
                        alm_flag_reg[gi] <= 1'b0;
                    end else if (set) begin
                        alm_flag_reg[gi] <= 1'b1;
                    end else if (clr) begin
                        alm_flag_reg[gi] <= 1'b0;
                    end
                end
            end
        end
    endgenerate

    // The outputs are the visible flags inverted, so flag and pin never disagree.
    assign irq_out_a_n = ~alm_flag_vis[rtctcf_pkg::FLAG_WEEKLY];
    assign irq_out_b_n = ~alm_flag_vis[rtctcf_pkg::FLAG_DAILY];

    // ************************************************************
    // Read data selection
    // ************************************************************
    logic [7:0] rsel;

    always_comb begin
        case (lcmd_reg.addr)
            rtctcf_pkg::ADDR_SECONDS: rsel = sec_reg;
            rtctcf_pkg::ADDR_MINUTES: rsel = min_reg;
            rtctcf_pkg::ADDR_HOURS:   rsel = hour_reg;
            rtctcf_pkg::ADDR_WEEKDAY: rsel = wday_reg;
            rtctcf_pkg::ADDR_MDAY:    rsel = mday_reg;
            rtctcf_pkg::ADDR_MONTH:   rsel = mon_reg;
            rtctcf_pkg::ADDR_YEAR:    rsel = year_reg;
            rtctcf_pkg::ADDR_FLAGS:   rsel = {6'h00, alm_flag_vis};
            default:                  rsel = 8'h00;
        endcase
    end

    // ************************************************************
    // Core registers
    // ************************************************************
    // Power-on contents are arbitrary by nature; a plain date is loaded.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            creq_s1_reg  <= 1'b0;
            creq_s2_reg  <= 1'b0;
            creq_s3_reg  <= 1'b0;
            cack_tgl_reg <= 1'b0;
            crdata_reg   <= 8'h00;
            div_reg      <= '0;
            sec_reg      <= rtctcf_pkg::RST_TIME;
            min_reg      <= rtctcf_pkg::RST_TIME;
            hour_reg     <= rtctcf_pkg::RST_TIME;
            wday_reg     <= rtctcf_pkg::RST_TIME;
            mday_reg     <= rtctcf_pkg::RST_DATE;
            mon_reg      <= rtctcf_pkg::RST_DATE;
            year_reg     <= rtctcf_pkg::RST_TIME;
        end else if (ce) begin
            creq_s1_reg <= lreq_tgl_reg;
            creq_s2_reg <= creq_s1_reg;
            creq_s3_reg <= creq_s2_reg;
            if (cexec) begin
                crdata_reg   <= rsel;
                cack_tgl_reg <= ~cack_tgl_reg;
            end
            if (sec_write || tick) begin
                div_reg <= '0;
            end else begin
                div_reg <= div_reg + rtctcf_pkg::DIV_W'(1);
            end
            sec_reg  <= sec_next;
            min_reg  <= min_next;
            hour_reg <= hour_next;
            wday_reg <= wday_next;
            mday_reg <= mday_next;
            mon_reg  <= mon_next;
            year_reg <= year_next;
        end
    end
endmodule // rtctcf_core
`default_nettype wire

// ==== rtctcf_checker.sv ====
// Port-level assertions for the timekeeping and alarm flag core.
`timescale 1ns/1ps
`default_nettype none
module rtctcf_checker (
    input wire logic                    clk,
    input wire logic                    nrst,
    input wire logic                    ce,
    input wire logic                    hour_mode_24,
    input wire logic                    weekly_alarm_enable,
    input wire logic                    daily_alarm_enable,
    input wire logic                    weekly_alarm_equal,
    input wire logic                    daily_alarm_equal,
    input wire logic                    irq_out_a_n,
    input wire logic                    irq_out_b_n,
    input wire logic                    link_clk,
    input wire logic                    host_req,
    input wire rtctcf_pkg::rtctcf_req_t host_cmd,
    input wire logic                    host_ready,
    input wire logic                    host_done,
    input wire logic [7:0]              host_rdata
);
    // ************************************************************
    // Weekly alarm delay tracker, alarm output and link handshake assertions
    // ************************************************************
    // Enabled cycles since the weekly match rose, held at FFF once reached; zero while disabled.
    logic [11:0] wait_a_reg;
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst)
            wait_a_reg <= 12'h000;
        else if (!weekly_alarm_enable)
            wait_a_reg <= 12'h000;
        else if (ce && $rose(weekly_alarm_equal))
            wait_a_reg <= 12'h001;
        else if (ce && wait_a_reg != 12'h000 && wait_a_reg != 12'hFFF)
            wait_a_reg <= wait_a_reg + 12'h001;
    end

    sequence s_ack;
        host_ready && host_done;
    endsequence

    a_irq_a_off: assert property (@(posedge clk) disable iff (!nrst)
        !weekly_alarm_enable |-> irq_out_a_n) else $error("irq a low while disabled");
    a_irq_b_off: assert property (@(posedge clk) disable iff (!nrst)
        !daily_alarm_enable |-> irq_out_b_n) else $error("irq b low while disabled");
    a_irq_a_window: assert property (@(posedge clk) disable iff (!nrst)
        $fell(irq_out_a_n) |-> wait_a_reg >= 12'h5D7 && wait_a_reg <= 12'h5E1)
        else $error("irq a fell outside delay window");
    a_irq_a_late: assert property (@(posedge clk) disable iff (!nrst)
        wait_a_reg == 12'h5E6 |-> !irq_out_a_n) else $error("irq a not set after delay");
    a_clear_by_write: assert property (@(posedge clk) disable iff (!nrst)
        $rose(irq_out_a_n) && weekly_alarm_enable |-> !host_ready)
        else $error("irq a released without a write");
    a_done_after_ready: assert property (@(posedge link_clk) disable iff (!nrst)
        $rose(host_ready) |-> s_ack) else $error("done does not follow ready");
    a_done_single: assert property (@(posedge link_clk) disable iff (!nrst)
        host_done |=> !host_done) else $error("done longer than one cycle");
    a_busy_bounded: assert property (@(posedge link_clk) disable iff (!nrst)
        $fell(host_ready) |-> ##[1:40] host_ready) else $error("transfer hangs");
    a_take_needs_req: assert property (@(posedge link_clk) disable iff (!nrst)
        $fell(host_ready) |-> $past(host_req)) else $error("busy without request");
endmodule // rtctcf_checker

bind rtctcf_core rtctcf_checker rtctcf_checker_i (.*);
`default_nettype wire

// ==== rtctcf_host_model.sv ====
// Host processor model that issues single-byte register transfers on the link port.
`timescale 1ns/1ps
`default_nettype none
module rtctcf_host_model (
    input  wire logic                   link_clk,
    input  wire logic                   host_ready,
    input  wire logic                   host_done,
    input  wire logic [7:0]             host_rdata,
    output var  logic                   host_req,
    output var  rtctcf_pkg::rtctcf_req_t host_cmd
);
    // ************************************************************
    // Transfer task
    // ************************************************************
    int unsigned gap = 0;
    initial begin
        host_req = 1'b0;
        host_cmd = '0;
    end
    // Callers may hand over values with set upper bits and unmapped addresses.
    task automatic xfer(input logic we, input logic [3:0] addr, input logic [7:0] wdata,
                        output logic [7:0] rdata);
        int n;
        n = 0;
        repeat (gap + 1) @(posedge link_clk);
        host_req <= 1'b1;
        host_cmd <= '{we: we, addr: addr, wdata: wdata};
        do @(negedge link_clk); while (!host_ready && ++n < 200);
        @(posedge link_clk);
        // A released command shows a changed pattern, never the stale request.
        host_req <= 1'b0;
        host_cmd <= rtctcf_pkg::rtctcf_req_t'(~host_cmd);
        n = 0;
        do @(negedge link_clk); while (!host_done && ++n < 200);
        rdata = host_done ? host_rdata : 8'hXX;
    endtask
endmodule // rtctcf_host_model
`default_nettype wire

// ==== tb_top.sv ====
// Self-checking testbench for the timekeeping and alarm flag core.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    // ************************************************************
    // Clocks, stimulus and scenarios
    // ************************************************************
    localparam int SDIV = 1000;
    logic clk = 1'b0;
    logic link_clk = 1'b0;
    logic nrst = 1'b0;
    logic ce = 1'b1;
    logic mode24 = 1'b1;
    logic wk_en = 1'b0;
    logic dy_en = 1'b0;
    logic wk_eq = 1'b0;
    logic dy_eq = 1'b0;
    logic irq_a_n, irq_b_n, host_req, host_ready, host_done;
    logic [7:0] host_rdata;
    rtctcf_pkg::rtctcf_req_t host_cmd;
    int n_errors = 0;
    int num_checks = 0;

    always #5 clk = ~clk;
    // The link clock is offset so its edges never meet the core clock edges.
    initial begin
        #1.3;
        forever #3 link_clk = ~link_clk;
    end

    rtctcf_core #(.SEC_DIV(SDIV)) rtctcf_core_i (.*, .hour_mode_24(mode24),
        .weekly_alarm_enable(wk_en), .daily_alarm_enable(dy_en), .weekly_alarm_equal(wk_eq),
        .daily_alarm_equal(dy_eq), .irq_out_a_n(irq_a_n), .irq_out_b_n(irq_b_n));
    rtctcf_host_model rtctcf_host_model_i (.*);

    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        logic [7:0] old;
        rtctcf_host_model_i.xfer(1'b1, a, d, old);
    endtask
    task automatic rc(input logic [3:0] a, input logic [7:0] exp, input string what);
        logic [7:0] d;
        rtctcf_host_model_i.xfer(1'b0, a, 8'h00, d);
        check(what, d, exp);
    endtask
    task automatic ck_irq(input logic a, input logic b);
        @(negedge clk);
        check("irq a", {7'h00, irq_a_n}, {7'h00, a});
        check("irq b", {7'h00, irq_b_n}, {7'h00, b});
    endtask

    task automatic t_regs();
        wr(rtctcf_pkg::ADDR_MINUTES, 8'hB4);
        rc(rtctcf_pkg::ADDR_MINUTES, 8'h34, "minutes");
        wr(rtctcf_pkg::ADDR_WEEKDAY, 8'hFD);
        rc(rtctcf_pkg::ADDR_WEEKDAY, 8'h05, "weekday");
        wr(rtctcf_pkg::ADDR_MONTH, 8'hE9);
        rc(rtctcf_pkg::ADDR_MONTH, 8'h09, "month");
        wr(4'h8, 8'h55);
        rc(4'h8, 8'h00, "unmapped");
    endtask

    task automatic t_carry();
        logic [112:0] tab [10];
        tab[0] = {1'b1, 56'h99123106235959, 56'h00010100000000};
        tab[1] = {1'b1, 56'h00022802235959, 56'h00022903000000};
        tab[2] = {1'b1, 56'h04022903235959, 56'h04030104000000};
        tab[3] = {1'b1, 56'h01022801235959, 56'h01030102000000};
        tab[4] = {1'b1, 56'h21043000235959, 56'h21050101000000};
        tab[5] = {1'b1, 56'h21013000235959, 56'h21013101000000};
        tab[6] = {1'b0, 56'h21061502315959, 56'h21061603120000};
        tab[7] = {1'b0, 56'h21061502115959, 56'h21061502320000};
        tab[8] = {1'b1, 56'h21061502195959, 56'h21061502200000};
        tab[9] = {1'b1, 56'h21073105235959, 56'h21080106000000};
        foreach (tab[k]) begin
            @(posedge clk);
            mode24 <= tab[k][112];
            // Seconds go last so the divider restarts a full second before the carry.
            for (int i = 6; i >= 0; i--) wr(4'(i), tab[k][56 + 8 * i +: 8]);
            repeat (SDIV + SDIV / 5) @(posedge clk);
            for (int i = 0; i < 7; i++) rc(4'(i), tab[k][8 * i +: 8], "count");
        end
    endtask

    task automatic t_div();
        repeat (SDIV / 2) @(posedge clk);
        wr(rtctcf_pkg::ADDR_SECONDS, 8'h10);
        @(posedge clk);
        ce <= 1'b0;
        repeat (SDIV) @(posedge clk);
        ce <= 1'b1;
        repeat (SDIV * 3 / 10) @(posedge clk);
        rtctcf_host_model_i.gap = 7;
        rc(rtctcf_pkg::ADDR_SECONDS, 8'h10, "seconds held");
        rtctcf_host_model_i.gap = 0;
        repeat (SDIV * 8 / 10) @(posedge clk);
        rc(rtctcf_pkg::ADDR_SECONDS, 8'h11, "seconds tick");
    endtask

    task automatic t_alarm();
        @(posedge clk);
        wk_en <= 1'b1;
        dy_en <= 1'b1;
        @(posedge clk);
        wk_eq <= 1'b1;
        dy_eq <= 1'b1;
        repeat (1490) @(posedge clk);
        ck_irq(1'b1, 1'b1);
        repeat (30) @(posedge clk);
        ck_irq(1'b0, 1'b0);
        rc(rtctcf_pkg::ADDR_FLAGS, 8'h03, "flags set");
        wr(rtctcf_pkg::ADDR_FLAGS, 8'hFF);
        ck_irq(1'b0, 1'b0);
        wr(rtctcf_pkg::ADDR_FLAGS, 8'h01);
        ck_irq(1'b1, 1'b0);
        rc(rtctcf_pkg::ADDR_FLAGS, 8'h01, "flags daily");
        @(posedge clk);
        wk_eq <= 1'b0;
        @(posedge clk);
        wk_eq <= 1'b1;
        repeat (1530) @(posedge clk);
        ck_irq(1'b0, 1'b0);
        @(posedge clk);
        dy_en <= 1'b0;
        ck_irq(1'b0, 1'b1);
        rc(rtctcf_pkg::ADDR_FLAGS, 8'h02, "flags weekly");
        wr(rtctcf_pkg::ADDR_FLAGS, 8'h00);
        rc(rtctcf_pkg::ADDR_FLAGS, 8'h00, "flags clear");
        ck_irq(1'b1, 1'b1);
    endtask

    task automatic final_report();
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    initial begin
        repeat (8) @(posedge clk);
        nrst <= 1'b1;
        repeat (4) @(posedge clk);
        t_regs();
        t_carry();
        t_div();
        t_alarm();
        final_report();
    end
    initial begin
        #500000;
        n_errors++;
        final_report();
    end
endmodule // tb_top
`default_nettype wire
